//--- logic/scan_access_regs.svh
// Constants for the scan-chain register access block.
// Assumes a boundary-scan instruction register four bits wide.
`ifndef SCAN_ACCESS_REGS_SVH
`define SCAN_ACCESS_REGS_SVH

`define IR_SCAN_N 4'h2
`define IR_INTEST 4'hC
`define IR_BYPASS 4'hF
`define IR_CAPTURE 4'h1
`define CHAIN_ACCESS 4'h6
`define CHAIN_RESET 4'h0

`define REG_MAIN 7'h00
`define REG_CONFIG 7'h01
`define REG_AUTH 7'h7E
`define REG_COUNT 128

`define LOCK_BIT 22
`define ALT_IF_BIT 27

`define REG_RESET 32'h0000_0000
`define CONFIG_VALUE 32'h0800_0000

`endif

//--- logic/scan_access_pkg.sv
// Types for the scan-chain register access block.
// Assumes the constants header is included by the design file.
package scan_access_pkg;

	typedef enum logic [3:0] {
		TEST_RESET = 4'b0000,
		RUN_IDLE = 4'b0001,
		SELECT_DR = 4'b0010,
		CAPTURE_DR = 4'b0011,
		SHIFT_DR = 4'b0100,
		EXIT1_DR = 4'b0101,
		PAUSE_DR = 4'b0110,
		EXIT2_DR = 4'b0111,
		UPDATE_DR = 4'b1000,
		SELECT_IR = 4'b1001,
		CAPTURE_IR = 4'b1010,
		SHIFT_IR = 4'b1011,
		EXIT1_IR = 4'b1100,
		PAUSE_IR = 4'b1101,
		EXIT2_IR = 4'b1110,
		UPDATE_IR = 4'b1111
	} tap_state_type;

	// Shift order is least significant bit first, so the select bit leaves last.
	typedef struct packed {
		logic write;
		logic [6:0] addr;
		logic [31:0] data;
	} access_type;

	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
		logic noninvasive_debug_enable;
	} pins_type;

endpackage

//--- logic/scan_access.sv
// Boundary-scan extension giving a debug probe access to registers 0 to 127.
// Assumes probe pins arrive asynchronously and the software port is on CLK.
// Operation
// R1 - The access chain lives behind the scan controller and is chain number 6.
// R2 - The chain is 40 bits: 32 data, 7 address and one read or write bit.
// R3 - A write carries data, register number and a one in the select bit.
// R4 - A read carries the register number and a zero; its data field is ignored.
// R5 - The access happens on entry to the data update state, never during shift.
// R6 - Only registers 0x000 to 0x07F can be reached through the chain.
// R7 - Lock bit 22 of the main control register makes the chain read-only.
// R8 - Only on-chip software can change the lock bit; the probe cannot.
// R9 - Bit 27 of the configuration code register reports another access port.
// R10 - The register file takes accesses from both ports at the same time.
// R11 - Software writes zero to bits of later versions and ignores their value.
// R12 - Software never writes read-only registers, reserved bits or encodings.
// R13 - Register access works normally while non-invasive debug is disabled.
// R14 - A read loads the register into the data field at the next capture.
// R15 - Data sits lowest, then address, then the select bit on top.
`timescale 1ns/1ps
`include "scan_access_regs.svh"

module scan_access (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic TCK,
	input wire logic TMS,
	input wire logic TDI,
	input wire logic NONINVASIVE_DEBUG_ENABLE,
	input wire logic SW_WE,
	input wire logic [6:0] SW_ADDR,
	input wire logic [31:0] SW_WDATA,
	output logic TDO,
	output logic TDO_OE_N,
	output logic [31:0] SW_RDATA,
	output logic [31:0] MAIN_CONTROL
);

	scan_access_pkg::pins_type meta;
	scan_access_pkg::pins_type pins;
	logic tck_last;
	logic tck_rise;
	logic tck_fall;

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			meta <= '0;
			pins <= '0;
			tck_last <= 1'b0;
		end else if (CE) begin
			meta <= {TCK, TMS, TDI, NONINVASIVE_DEBUG_ENABLE};
			pins <= meta;
			tck_last <= pins.tck;
		end
	end

	assign tck_rise = CE & pins.tck & ~tck_last;
	assign tck_fall = CE & ~pins.tck & tck_last;

	scan_access_pkg::tap_state_type state, next_state;
	logic [3:0] ir, next_ir, ir_shift, next_ir_shift;
	logic [3:0] chain, next_chain, chain_shift, next_chain_shift;
	scan_access_pkg::access_type access, next_access;
	logic bypass, next_bypass;
	logic [31:0] read_latch, next_read_latch;
	logic tdo, next_tdo, tdo_oe_n, next_tdo_oe_n;
	logic [31:0] regs [`REG_COUNT];
	logic chain_sel;
	logic jtag_upd;
	logic jtag_we;
	logic [31:0] sw_rdata, next_sw_rdata;

	// R1 chain six select
	assign chain_sel = (ir == `IR_INTEST) && (chain == `CHAIN_ACCESS);
	// R5 access on update
	assign jtag_upd = tck_rise && chain_sel && (next_state == scan_access_pkg::UPDATE_DR);
	// R3 write request
	assign jtag_we = jtag_upd && access.write;

	always_comb begin
		next_state = state;
		next_ir = ir;
		next_ir_shift = ir_shift;
		next_chain = chain;
		next_chain_shift = chain_shift;
		next_access = access;
		next_bypass = bypass;
		next_read_latch = read_latch;
		next_tdo = tdo;
		next_tdo_oe_n = tdo_oe_n;
		if (tck_rise) begin
			case (state)
				scan_access_pkg::TEST_RESET:
					next_state = pins.tms ? scan_access_pkg::TEST_RESET
						: scan_access_pkg::RUN_IDLE;
				scan_access_pkg::RUN_IDLE:
					next_state = pins.tms ? scan_access_pkg::SELECT_DR
						: scan_access_pkg::RUN_IDLE;
				scan_access_pkg::SELECT_DR:
					next_state = pins.tms ? scan_access_pkg::SELECT_IR
						: scan_access_pkg::CAPTURE_DR;
				scan_access_pkg::CAPTURE_DR, scan_access_pkg::SHIFT_DR:
					next_state = pins.tms ? scan_access_pkg::EXIT1_DR
						: scan_access_pkg::SHIFT_DR;
				scan_access_pkg::EXIT1_DR:
					next_state = pins.tms ? scan_access_pkg::UPDATE_DR
						: scan_access_pkg::PAUSE_DR;
				scan_access_pkg::PAUSE_DR:
					next_state = pins.tms ? scan_access_pkg::EXIT2_DR
						: scan_access_pkg::PAUSE_DR;
				scan_access_pkg::EXIT2_DR:
					next_state = pins.tms ? scan_access_pkg::UPDATE_DR
						: scan_access_pkg::SHIFT_DR;
				scan_access_pkg::SELECT_IR:
					next_state = pins.tms ? scan_access_pkg::TEST_RESET
						: scan_access_pkg::CAPTURE_IR;
				scan_access_pkg::CAPTURE_IR, scan_access_pkg::SHIFT_IR:
					next_state = pins.tms ? scan_access_pkg::EXIT1_IR
						: scan_access_pkg::SHIFT_IR;
				scan_access_pkg::EXIT1_IR:
					next_state = pins.tms ? scan_access_pkg::UPDATE_IR
						: scan_access_pkg::PAUSE_IR;
				scan_access_pkg::PAUSE_IR:
					next_state = pins.tms ? scan_access_pkg::EXIT2_IR
						: scan_access_pkg::PAUSE_IR;
				scan_access_pkg::EXIT2_IR:
					next_state = pins.tms ? scan_access_pkg::UPDATE_IR
						: scan_access_pkg::SHIFT_IR;
				default:
					next_state = pins.tms ? scan_access_pkg::SELECT_DR
						: scan_access_pkg::RUN_IDLE;
			endcase
			case (state)
				scan_access_pkg::TEST_RESET: begin
					next_ir = `IR_BYPASS;
					next_chain = `CHAIN_RESET;
				end
				scan_access_pkg::CAPTURE_IR:
					next_ir_shift = `IR_CAPTURE;
				scan_access_pkg::SHIFT_IR:
					next_ir_shift = {pins.tdi, ir_shift[3:1]};
				scan_access_pkg::CAPTURE_DR: begin
					next_bypass = 1'b0;
					// R14 read data capture
					if (chain_sel) begin
						next_access.data = read_latch;
					end
				end
				scan_access_pkg::SHIFT_DR: begin
					next_bypass = pins.tdi;
					if (ir == `IR_SCAN_N) begin
						next_chain_shift = {pins.tdi, chain_shift[3:1]};
					end
					// R2 forty bit shift
					// R15 data shifted first
					if (chain_sel) begin
						next_access = {pins.tdi, access[39:1]};
					end
				end
				default: begin
				end
			endcase
			if (next_state == scan_access_pkg::UPDATE_IR) begin
				next_ir = ir_shift;
			end
			// R1 chain number update
			if (next_state == scan_access_pkg::UPDATE_DR && ir == `IR_SCAN_N) begin
				next_chain = chain_shift;
			end
			// R4 read ignores data field
			if (chain_sel && next_state == scan_access_pkg::UPDATE_DR && !access.write) begin
				next_read_latch = regs[access.addr];
			end
		end
		// Output changes on the falling edge so the probe samples it stable.
		if (tck_fall) begin
			next_tdo_oe_n = !(state == scan_access_pkg::SHIFT_DR
				|| state == scan_access_pkg::SHIFT_IR);
			if (state == scan_access_pkg::SHIFT_IR) begin
				next_tdo = ir_shift[0];
			end else if (ir == `IR_SCAN_N) begin
				next_tdo = chain_shift[0];
			end else if (chain_sel) begin
				next_tdo = access.data[0];
			end else begin
				next_tdo = bypass;
			end
		end
		next_sw_rdata = regs[SW_ADDR];
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			state <= scan_access_pkg::TEST_RESET;
			ir <= `IR_BYPASS;
			ir_shift <= `IR_CAPTURE;
			chain <= `CHAIN_RESET;
			chain_shift <= `CHAIN_RESET;
			access <= '0;
			bypass <= 1'b0;
			read_latch <= `REG_RESET;
			tdo <= 1'b0;
			tdo_oe_n <= 1'b1;
			sw_rdata <= `REG_RESET;
		end else if (CE) begin
			state <= next_state;
			ir <= next_ir;
			ir_shift <= next_ir_shift;
			chain <= next_chain;
			chain_shift <= next_chain_shift;
			access <= next_access;
			bypass <= next_bypass;
			read_latch <= next_read_latch;
			tdo <= next_tdo;
			tdo_oe_n <= next_tdo_oe_n;
			sw_rdata <= next_sw_rdata;
		end
	end

	// R6 seven bit register space
	// R13 access ignores debug enable
	for (genvar i = 0; i < `REG_COUNT; i++) begin : entry
		logic [31:0] next_value;
		logic sw_hit;
		logic jtag_hit;
		assign sw_hit = SW_WE && (SW_ADDR == 7'(i));
		assign jtag_hit = jtag_we && (access.addr == 7'(i));
		always_comb begin
			next_value = regs[i];
			if (7'(i) == `REG_CONFIG) begin
				// R9 other port present
				next_value = `CONFIG_VALUE;
			end else if (7'(i) == `REG_AUTH) begin
				next_value = {31'h0000_0000, pins.noninvasive_debug_enable};
			end else if (sw_hit) begin
				// R10 software wins a same-register collision
				next_value = SW_WDATA;
			end else if (jtag_hit && !regs[0][`LOCK_BIT]) begin
				// R7 lock blocks probe writes
				next_value = access.data;
				if (i == 0) begin
					// R8 lock kept from probe
					next_value[`LOCK_BIT] = regs[0][`LOCK_BIT];
				end
			end
		end
		always_ff @(posedge CLK) begin
			if (!RST_N) begin
				regs[i] <= (7'(i) == `REG_CONFIG) ? `CONFIG_VALUE : `REG_RESET;
			end else if (CE) begin
				regs[i] <= next_value;
			end
		end
	end

	assign TDO = tdo;
	assign TDO_OE_N = tdo_oe_n;
	assign SW_RDATA = sw_rdata;
	assign MAIN_CONTROL = regs[0];

	sequence seq_probe_write;
		jtag_we && !regs[0][`LOCK_BIT] && !(SW_WE && SW_ADDR == access.addr);
	endsequence
	sequence seq_probe_read;
		jtag_upd && !access.write;
	endsequence

	a_chain_select: assert property (@(posedge CLK) disable iff (!RST_N) // R1
		CE && tck_rise && next_state == scan_access_pkg::UPDATE_DR && ir == `IR_SCAN_N
		|=> chain == $past(chain_shift)) else $error("chain select not updated");
	a_shift_step: assert property (@(posedge CLK) disable iff (!RST_N) // R2
		tck_rise && chain_sel && state == scan_access_pkg::SHIFT_DR
		|=> access == {$past(pins.tdi), $past(access[39:1])}) else $error("bad shift");
	a_write_store: assert property (@(posedge CLK) disable iff (!RST_N) // R3
		seq_probe_write and (access.addr > `REG_CONFIG && access.addr != `REG_AUTH)
		|=> regs[$past(access.addr)] == $past(access.data)) else $error("write lost");
	a_read_nowrite: assert property (@(posedge CLK) disable iff (!RST_N) // R4
		seq_probe_read and (!SW_WE && access.addr != `REG_AUTH)
		|=> regs[$past(access.addr)] == $past(regs[access.addr]))
		else $error("read changed register");
	a_update_only: assert property (@(posedge CLK) disable iff (!RST_N) // R5
		jtag_we |-> tck_rise && (state == scan_access_pkg::EXIT1_DR
		|| state == scan_access_pkg::EXIT2_DR)) else $error("access outside update");
	a_lock_blocks: assert property (@(posedge CLK) disable iff (!RST_N) // R7
		jtag_we && regs[0][`LOCK_BIT] && !SW_WE && access.addr != `REG_AUTH
		|=> regs[$past(access.addr)] == $past(regs[access.addr]))
		else $error("locked write taken");
	a_lock_kept: assert property (@(posedge CLK) disable iff (!RST_N) // R8
		jtag_we && access.addr == `REG_MAIN && !SW_WE
		|=> regs[0][`LOCK_BIT] == $past(regs[0][`LOCK_BIT])) else $error("probe set lock");
	a_config_bit: assert property (@(posedge CLK) disable iff (!RST_N) // R9
		regs[1][`ALT_IF_BIT] ##1 regs[1][`ALT_IF_BIT]) else $error("config bit lost");
	a_sw_write: assert property (@(posedge CLK) disable iff (!RST_N) // R10
		CE && SW_WE && SW_ADDR > `REG_CONFIG && SW_ADDR != `REG_AUTH
		|=> regs[$past(SW_ADDR)] == $past(SW_WDATA)) else $error("software write lost");
	a_read_capture: assert property (@(posedge CLK) disable iff (!RST_N) // R14
		seq_probe_read |=> read_latch == $past(regs[access.addr]))
		else $error("read not latched");

endmodule

//--- verification/jtag_probe.sv
// Debug probe model driving the scan port of the register access block.
// Assumes the caller runs its tasks from the bench; pins move on clk edges.
`timescale 1ns/1ps

module jtag_probe (
	input wire logic clk,
	input wire logic tdo,
	output logic tck,
	output logic tms,
	output logic tdi
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	// One link clock of 800 ns; tdo is taken well after its fall settles.
	// Outside data bits tdi flips so a stale level is never trusted.
	task automatic tick(input logic m, input logic d, input logic drv, output logic o);
		tms <= m;
		tdi <= drv ? d : ~tdi;
		tck <= 1'b0;
		repeat (4) @(posedge clk);
		tck <= 1'b1;
		@(posedge clk);
		o = tdo;
		repeat (3) @(posedge clk);
	endtask

	task automatic tap_reset();
		logic o;
		@(posedge clk);
		repeat (5) tick(1'b1, 1'b0, 1'b0, o);
		tick(1'b0, 1'b0, 1'b0, o);
	endtask

	task automatic scan(input logic ir, input int n, input logic [39:0] din,
		output logic [39:0] dout);
		logic o;
		dout = '0;
		@(posedge clk);
		tick(1'b1, 1'b0, 1'b0, o);
		if (ir) tick(1'b1, 1'b0, 1'b0, o);
		tick(1'b0, 1'b0, 1'b0, o);
		tick(1'b0, 1'b0, 1'b0, o);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], 1'b1, o);
			dout[i] = o;
		end
		tick(1'b1, 1'b0, 1'b0, o);
		tick(1'b0, 1'b0, 1'b0, o);
	endtask
endmodule

//--- verification/jtag_register_access_chain_tb.sv
// Self-checking bench for the scan-chain register access block.
// Assumes the probe model sits on the scan pins and software on CLK.
`timescale 1ns/1ps

module jtag_register_access_chain_tb;
	logic clk, rst_n, ce, noninvasive_debug_enable, sw_we, tdo, tdo_oe_n, tck, tms, tdi;
	logic [6:0] sw_addr;
	logic [31:0] sw_wdata, sw_rdata, main_control, rd;
	logic [39:0] rx;
	int error_cnt = 0;
	int num_checks = 0;
	int cyc = 0;

	scan_access u_scan_access (.CLK(clk), .RST_N(rst_n), .CE(ce), .TCK(tck),
		.TMS(tms), .TDI(tdi), .NONINVASIVE_DEBUG_ENABLE(noninvasive_debug_enable), .SW_WE(sw_we), .SW_ADDR(sw_addr),
		.SW_WDATA(sw_wdata), .TDO(tdo), .TDO_OE_N(tdo_oe_n), .SW_RDATA(sw_rdata),
		.MAIN_CONTROL(main_control));

	// A released data-out line floats to the pull-up level.
	jtag_probe u_jtag_probe (.clk(clk), .tdo(tdo_oe_n ? 1'b1 : tdo), .tck(tck),
		.tms(tms), .tdi(tdi));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// only defined bits and writable registers are written
	task automatic sw_wr(input logic [6:0] a, input logic [31:0] d);
		@(posedge clk);
		sw_we <= 1'b1;
		sw_addr <= a;
		sw_wdata <= d;
		@(posedge clk);
		sw_we <= 1'b0;
	endtask

	task automatic sw_rd(input logic [6:0] a, output logic [31:0] d);
		@(posedge clk);
		sw_addr <= a;
		repeat (2) @(posedge clk);
		#1 d = sw_rdata;
	endtask

	task automatic jw(input logic [6:0] a, input logic [31:0] d);
		u_jtag_probe.scan(1'b0, 40, {1'b1, a, d}, rx);
	endtask

	// The second frame carries out what the first one asked for.
	task automatic jr(input logic [6:0] a, output logic [31:0] d);
		u_jtag_probe.scan(1'b0, 40, {1'b0, a, 32'hFFFF_FFFF}, rx);
		u_jtag_probe.scan(1'b0, 40, {1'b0, a, 32'h0000_0000}, rx);
		d = rx[31:0];
	endtask

	task automatic t_reset();
		sw_rd(7'h01, rd);
		chk("config_code_reg", 32'h0800_0000, rd);
		sw_rd(7'h7E, rd);
		chk("authentication_status_reg", 32'h0000_0001, rd);
		chk("main_control", 32'h0000_0000, main_control);
		chk("tdo_oe_n", 32'h0000_0001, {31'h0, tdo_oe_n});
	endtask

	task automatic t_select();
		u_jtag_probe.tap_reset();
		u_jtag_probe.scan(1'b1, 4, 40'h2, rx);
		chk("instruction capture", 32'h0000_0001, rx[31:0]);
		u_jtag_probe.scan(1'b0, 4, 40'h6, rx);
		u_jtag_probe.scan(1'b1, 4, 40'hC, rx);
	endtask

	task automatic t_write();
		jw(7'h05, 32'hA5A5_1234);
		sw_rd(7'h05, rd);
		chk("probe write", 32'hA5A5_1234, rd);
		jw(7'h7F, 32'h0F0F_F0F0);
		jr(7'h7F, rd);
		chk("top register", 32'h0F0F_F0F0, rd);
	endtask

	task automatic t_read();
		sw_wr(7'h10, 32'h1234_5678);
		jr(7'h10, rd);
		chk("probe read", 32'h1234_5678, rd);
		sw_rd(7'h10, rd);
		chk("read leaves data", 32'h1234_5678, rd);
	endtask

	task automatic t_lock();
		jw(7'h00, 32'h0040_0003);
		sw_rd(7'h00, rd);
		chk("lock from probe", 32'h0000_0003, main_control);
		sw_wr(7'h00, 32'h0040_0000);
		jw(7'h05, 32'h0000_0000);
		sw_rd(7'h05, rd);
		chk("locked write", 32'hA5A5_1234, rd);
		jr(7'h05, rd);
		chk("locked read", 32'hA5A5_1234, rd);
		sw_wr(7'h00, 32'h0000_0000);
	endtask

	task automatic t_noninvasive_debug_enable();
		@(posedge clk);
		noninvasive_debug_enable <= 1'b0;
		jw(7'h06, 32'hDEAD_BEEF);
		sw_rd(7'h06, rd);
		chk("write without debug", 32'hDEAD_BEEF, rd);
		sw_rd(7'h7E, rd);
		chk("authentication_status_reg", 32'h0000_0000, {31'h0, rd[0]});
		@(posedge clk);
		noninvasive_debug_enable <= 1'b1;
	endtask

	task automatic t_concur();
		fork
			jw(7'h21, 32'h2121_2121);
			sw_wr(7'h20, 32'h2020_2020);
		join
		sw_rd(7'h21, rd);
		chk("probe side", 32'h2121_2121, rd);
		sw_rd(7'h20, rd);
		chk("software side", 32'h2020_2020, rd);
	endtask

	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		noninvasive_debug_enable = 1'b1;
		sw_we = 1'b0;
		sw_addr = 7'h00;
		sw_wdata = 32'h0000_0000;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_select();
		t_write();
		t_read();
		t_lock();
		t_noninvasive_debug_enable();
		t_concur();
		give_verdict();
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			give_verdict();
		end
	end
endmodule
